// ---- rtl/rsc_pkg.sv ----
// Package of constants and carrier types for the serial command block
package rsc_pkg;
  // Command opcodes (values of this block's own instruction set)
  localparam logic [7:0] OP_READ = 8'h13;
  localparam logic [7:0] OP_WRITE = 8'h12;
  localparam logic [7:0] OP_NV_READ = 8'h03;
  localparam logic [7:0] OP_NV_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_NV_LATCH_SET = 8'h14;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_STORE = 8'h01;
  localparam logic [7:0] OP_UNLOCK = 8'h14;
  localparam logic [7:0] OP_ID_READ = 8'h33;
  localparam logic [7:0] OP_ID_STORE = 8'h32;
  localparam logic [7:0] OP_WATCHDOG_KICK = 8'h44;
  localparam logic [7:0] OP_RAM_ZERO = 8'h54;
  // Unlock key bytes
  localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_B = 8'haa;
  // Address map of clock registers and battery-backed memory
  localparam logic [7:0] CLK_REG_FIRST = 8'h00;
  localparam logic [7:0] CLK_REG_LAST = 8'h1f;
  localparam logic [7:0] SRAM_FIRST = 8'h20;
  localparam logic [7:0] SRAM_LAST = 8'h5f;
  localparam int SRAM_BYTES = 64;
  // Identity area window and bytes per command
  localparam logic [7:0] ID_LAST = 8'h0f;
  localparam logic [3:0] ID_MAX_BYTES = 4'h8;
  // Protection boundaries
  localparam logic [7:0] PROT_QUARTER = 8'hc0;
  localparam logic [7:0] PROT_HALF = 8'h80;
  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 3;
  // Nonvolatile write time and its cycle count at 10 MHz
  localparam int NV_WRITE_US = 5000;
  localparam int MCLK_MHZ = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_US * MCLK_MHZ;
  // Reset values
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Byte event passed from the link domain to the core
  typedef struct packed {
    logic [7:0] data;   // Byte value
    logic [3:0] index;  // Byte number within frame, saturating at 15
  } rsc_byte_t;

  // Memory write request towards the device cores
  typedef struct packed {
    logic strobe;       // One-cycle write pulse
    logic [7:0] addr;   // Target address
    logic [7:0] data;   // Byte to store
  } rsc_wr_t;
endpackage : rsc_pkg

// ---- rtl/rsc_link_rx.sv ----
// Serial link front end running on the link clock
`timescale 1ns/1ps
module rsc_link_rx (
  input wire logic sck,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [7:0] tx_byte,
  output logic so,
  output logic byte_tgl,
  output rsc_pkg::rsc_byte_t byte_out
);
  // Per-frame receive state in one struct
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [3:0] index;
  } rsc_rx_state_t;

  rsc_rx_state_t cur_ff;
  rsc_rx_state_t nxt_cur;
  logic tgl_ff; // Byte toggle, kept across frames
  logic nxt_tgl;
  rsc_pkg::rsc_byte_t last_ff; // Last whole byte, kept across frames
  rsc_pkg::rsc_byte_t nxt_last;
  logic [7:0] tx_hold_ff; // Output byte on falling edge
  logic [2:0] tx_cnt_ff;

  // Sample SI on rising edge, build bytes
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_tgl = tgl_ff;
    nxt_last = last_ff;
    nxt_cur.bit_cnt = cur_ff.bit_cnt + 3'h1;
    nxt_cur.shift = {cur_ff.shift[5:0], si};
    if (cur_ff.bit_cnt == 3'h7)
    begin
      // Byte complete: publish and toggle
      nxt_last.data = {cur_ff.shift, si};
      nxt_last.index = cur_ff.index;
      nxt_tgl = ~tgl_ff;
      if (cur_ff.index != 4'hf)
        nxt_cur.index = cur_ff.index + 4'h1;
    end
  end

  // Frame state cleared by chip select, which ends every frame
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  // Toggle and byte persist across frames; a known toggle after reset
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_ff <= 1'b0;
      last_ff <= '0;
    end
    else if (!cs_n)
    begin
      tgl_ff <= nxt_tgl;
      last_ff <= nxt_last;
    end
  end

  // Shift out on falling edge, MSB first
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      tx_cnt_ff <= 3'h0;
      tx_hold_ff <= 8'h00;
    end
    else
    begin
      tx_cnt_ff <= tx_cnt_ff + 3'h1;
      if (tx_cnt_ff == 3'h0)
        tx_hold_ff <= {tx_byte[6:0], 1'b0}; // Bit 7 already on the pin
      else
        tx_hold_ff <= {tx_hold_ff[6:0], 1'b0};
    end
  end

  assign so = (tx_cnt_ff == 3'h0) ? tx_byte[7] : tx_hold_ff[7];
  assign byte_tgl = tgl_ff;
  assign byte_out = last_ff;
endmodule : rsc_link_rx

// ---- rtl/rsc_sync.sv ----
// Two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
module rsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // Both stages as one struct
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } rsc_sync_t;

  rsc_sync_t st_ff;
  rsc_sync_t nxt_st;

  // Second stage reads only the first
  always_comb
  begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  // Register when enabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else if (ce)
      st_ff <= nxt_st;
  end

  assign q = st_ff.s2;
endmodule : rsc_sync

// ---- rtl/rsc_cmd_core.sv ----
// Serial command interpreter with write latch, protection and unlock
`timescale 1ns/1ps
module rsc_cmd_core #(
  parameter int NV_CYC = rsc_pkg::NV_WRITE_CYC
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  output logic SO,
  input wire logic ON_BATTERY,
  input wire logic [1:0] PROT_NV_IN,
  input wire logic [7:0] RD_DATA,
  input wire logic [7:0] ID_RD_DATA,
  input wire logic [7:0] NV_RD_DATA,
  output logic [7:0] RD_ADDR,
  output rsc_pkg::rsc_wr_t RTC_WR,
  output rsc_pkg::rsc_wr_t ID_WR,
  output rsc_pkg::rsc_wr_t NV_WR,
  output logic [1:0] PROT_NV_OUT,
  output logic PROT_NV_STORE,
  output logic WATCHDOG_KICK,
  output logic SRAM_ZERO,
  output logic STATUS_BUSY,
  output logic STATUS_LATCH
);
  // Frame kinds decoded from the opcode
  typedef enum logic [3:0] {
    K_NONE, K_READ, K_WRITE, K_NV_READ, K_NV_WRITE, K_ST_READ,
    K_ST_STORE, K_UNLOCK, K_ID_READ, K_ID_STORE, K_ZERO, K_OTHER
  } rsc_kind_t;

  // Unlock sequence progress
  typedef enum logic [1:0] {U_LOCKED, U_LATCH, U_KEY_A, U_OPEN} rsc_ul_t;

  // All core state
  typedef struct packed {
    rsc_kind_t kind;
    rsc_ul_t ul;
    logic [7:0] ptr;
    logic [7:0] pend_data;
    logic pend_valid;
    logic [7:0] key;
    logic latch;
    logic [1:0] prot;
    logic [15:0] busy_cnt;
    logic busy;
    logic [3:0] nv_count;
    logic [7:0] nv_addr;
    logic [63:0] nv_buf;
    logic [3:0] last_index;
    logic tgl_seen;
    logic frame_open;
    logic strap_done;
    logic [7:0] tx;
    logic kick;
    logic zero;
    rsc_pkg::rsc_wr_t wr_rtc;
    rsc_pkg::rsc_wr_t wr_id;
    rsc_pkg::rsc_wr_t wr_nv;
    logic prot_store;
  } rsc_core_t;

  rsc_core_t st_ff;
  rsc_core_t nxt_st;
  logic link_tgl;
  logic link_so;
  rsc_pkg::rsc_byte_t link_byte;
  logic [12:0] sync_q;
  logic tgl_s;
  logic cs_n_s;
  logic frame_end;
  logic new_byte;
  rsc_pkg::rsc_byte_t byte_s;

  // Map an opcode to its frame kind
  function automatic rsc_kind_t decode(input logic [7:0] op);
    rsc_kind_t k;
    k = K_OTHER;
    if (op == rsc_pkg::OP_READ) k = K_READ;
    else if (op == rsc_pkg::OP_WRITE) k = K_WRITE;
    else if (op == rsc_pkg::OP_NV_READ) k = K_NV_READ;
    else if (op == rsc_pkg::OP_NV_WRITE) k = K_NV_WRITE;
    else if (op == rsc_pkg::OP_STATUS_READ) k = K_ST_READ;
    else if (op == rsc_pkg::OP_STATUS_STORE) k = K_ST_STORE;
    else if (op == rsc_pkg::OP_UNLOCK) k = K_UNLOCK;
    else if (op == rsc_pkg::OP_ID_READ) k = K_ID_READ;
    else if (op == rsc_pkg::OP_ID_STORE) k = K_ID_STORE;
    else if (op == rsc_pkg::OP_RAM_ZERO) k = K_ZERO;
    return k;
  endfunction : decode

  // Next pointer with clock and SRAM region wrap
  function automatic logic [7:0] wrap_inc(input logic [7:0] a);
    logic [7:0] r;
    r = a + 8'h01;
    if (a == rsc_pkg::CLK_REG_LAST) r = rsc_pkg::CLK_REG_FIRST;
    else if (a == rsc_pkg::SRAM_LAST) r = rsc_pkg::SRAM_FIRST;
    return r;
  endfunction : wrap_inc

  // True when an array address is guarded by the protect bits
  function automatic logic is_protected(input logic [1:0] p,
                                        input logic [7:0] a);
    logic r;
    r = 1'b0;
    case (p)
      2'h1: r = (a >= rsc_pkg::PROT_QUARTER);
      2'h2: r = (a >= rsc_pkg::PROT_HALF);
      2'h3: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_protected

  // Link-clock front end
  rsc_link_rx u_link (
    .sck(SCK),
    .rst_n(RESETN),
    .cs_n(CS_N),
    .si(SI),
    .tx_byte(st_ff.tx),
    .so(link_so),
    .byte_tgl(link_tgl),
    .byte_out(link_byte)
  );

  // Byte data and its toggle change on the same link edge and cross the same two stages
  rsc_sync #(.WIDTH(14)) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .d({CS_N, link_tgl, link_byte}),
    .q({cs_n_s, tgl_s, sync_q[11:0]})
  );
  assign sync_q[12] = 1'b0;
  assign byte_s = sync_q[11:0];
  assign new_byte = (tgl_s != st_ff.tgl_seen);
  assign frame_end = cs_n_s && st_ff.frame_open;

  // Command interpretation
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.kick = 1'b0;
    nxt_st.zero = 1'b0;
    nxt_st.wr_rtc.strobe = 1'b0;
    nxt_st.wr_id.strobe = 1'b0;
    nxt_st.wr_nv.strobe = 1'b0;
    nxt_st.prot_store = 1'b0;
    // Catch stored protect level once after reset
    if (!st_ff.strap_done)
    begin
      nxt_st.prot = PROT_NV_IN;
      nxt_st.strap_done = 1'b1;
    end
    // Internal write cycle countdown
    if (st_ff.busy)
    begin
      if (st_ff.busy_cnt == 16'h0001)
        nxt_st.busy = 1'b0;
      nxt_st.busy_cnt = st_ff.busy_cnt - 16'h0001;
    end
    if (!cs_n_s)
      nxt_st.frame_open = 1'b1;
    if (new_byte)
    begin
      nxt_st.tgl_seen = tgl_s;
      nxt_st.last_index = byte_s.index;
      if (byte_s.index == 4'h0)
      begin
        nxt_st.kind = decode(byte_s.data);
        nxt_st.pend_valid = 1'b0;
        nxt_st.nv_count = 4'h0;
        // Simple commands act at once
        if (byte_s.data == rsc_pkg::OP_WATCHDOG_KICK)
          nxt_st.kick = 1'b1;
        if ((byte_s.data == rsc_pkg::OP_LATCH_SET ||
             byte_s.data == rsc_pkg::OP_NV_LATCH_SET) && !st_ff.busy)
          nxt_st.latch = 1'b1;
        if (byte_s.data == rsc_pkg::OP_LATCH_CLR && !st_ff.busy)
          nxt_st.latch = 1'b0;
        if (byte_s.data == rsc_pkg::OP_STATUS_READ)
          nxt_st.tx = {4'h0, st_ff.prot, st_ff.latch, st_ff.busy};
      end
      else if (byte_s.index == 4'h1)
      begin
        nxt_st.ptr = byte_s.data;
        nxt_st.nv_addr = byte_s.data;
        nxt_st.key = byte_s.data;
        nxt_st.pend_data = byte_s.data;
        // Preload first read byte
        if (st_ff.kind == K_READ)
          nxt_st.tx = ON_BATTERY ? 8'h00 : RD_DATA;
        else if (st_ff.kind == K_ID_READ)
          nxt_st.tx = ID_RD_DATA;
        else if (st_ff.kind == K_NV_READ)
          nxt_st.tx = st_ff.busy ? 8'h00 : NV_RD_DATA;
      end
      else
      begin
        // Data bytes
        case (st_ff.kind)
          K_READ, K_ID_READ, K_NV_READ:
          begin
            nxt_st.ptr = wrap_inc(st_ff.ptr);
          end
          K_WRITE:
          begin
            // Store previous byte, hold this one until completion
            if (st_ff.pend_valid && !ON_BATTERY)
            begin
              nxt_st.wr_rtc = '{1'b1, st_ff.ptr, st_ff.pend_data};
              nxt_st.ptr = wrap_inc(st_ff.ptr);
            end
            nxt_st.pend_data = byte_s.data;
            nxt_st.pend_valid = 1'b1;
          end
          K_NV_WRITE, K_ID_STORE:
          begin
            if (st_ff.nv_count < rsc_pkg::ID_MAX_BYTES)
            begin
              nxt_st.nv_buf[st_ff.nv_count*8 +: 8] = byte_s.data;
              nxt_st.nv_count = st_ff.nv_count + 4'h1;
            end
          end
          default:
          begin
            nxt_st.pend_valid = 1'b0;
          end
        endcase
      end
    end
    // Read pointer follows the address, output loaded per byte
    if (new_byte && byte_s.index >= 4'h2 && st_ff.kind == K_READ)
      nxt_st.tx = ON_BATTERY ? 8'h00 : RD_DATA;
    else if (new_byte && byte_s.index >= 4'h2 && st_ff.kind == K_ID_READ)
      nxt_st.tx = ID_RD_DATA;
    else if (new_byte && byte_s.index >= 4'h2 && st_ff.kind == K_NV_READ)
      nxt_st.tx = st_ff.busy ? 8'h00 : NV_RD_DATA;
    // Chip select rose: commit the frame
    if (frame_end)
    begin
      nxt_st.frame_open = 1'b0;
      nxt_st.kind = K_NONE;
      nxt_st.pend_valid = 1'b0;
      case (st_ff.kind)
        K_WRITE:
        begin
          // Last pending byte written only when no byte toggle arrives in the same cycle
          if (st_ff.pend_valid && !ON_BATTERY && !new_byte)
            nxt_st.wr_rtc = '{1'b1, st_ff.ptr, st_ff.pend_data};
          // A foreign write after unlocking drops the latch
          if (st_ff.ul == U_OPEN)
            nxt_st.latch = 1'b0;
          nxt_st.ul = U_LOCKED;
        end
        K_NV_WRITE:
        begin
          if (st_ff.latch && !st_ff.busy && st_ff.nv_count != 4'h0 &&
              !is_protected(st_ff.prot, st_ff.nv_addr))
          begin
            nxt_st.busy = 1'b1;
            nxt_st.busy_cnt = NV_CYC[15:0];
            nxt_st.wr_nv = '{1'b1, st_ff.nv_addr, st_ff.nv_buf[7:0]};
            nxt_st.latch = 1'b0;
          end
          if (st_ff.ul == U_OPEN)
          begin
            nxt_st.latch = 1'b0;
          end
          nxt_st.ul = U_LOCKED;
        end
        K_ID_STORE:
        begin
          // Unlock, latch, idle and ID address range checked; protect bits not consulted
          if (st_ff.ul == U_OPEN && st_ff.latch && !st_ff.busy &&
              st_ff.nv_count != 4'h0 &&
              st_ff.nv_addr <= rsc_pkg::ID_LAST)
          begin
            nxt_st.busy = 1'b1;
            nxt_st.busy_cnt = NV_CYC[15:0];
            nxt_st.wr_id = '{1'b1, st_ff.nv_addr, st_ff.nv_buf[7:0]};
          end
          nxt_st.latch = 1'b0;
          nxt_st.ul = U_LOCKED;
        end
        K_ST_STORE:
        begin
          if (st_ff.latch && !st_ff.busy &&
              st_ff.last_index == 4'h1)
          begin
            nxt_st.prot = {st_ff.pend_data[rsc_pkg::ST_PROT_HI],
                           st_ff.pend_data[rsc_pkg::ST_PROT_LO]};
            nxt_st.prot_store = 1'b1;
            nxt_st.busy = 1'b1;
            nxt_st.busy_cnt = NV_CYC[15:0];
            nxt_st.latch = 1'b0;
          end
          nxt_st.ul = U_LOCKED;
        end
        K_UNLOCK:
        begin
          // Sequence: latch set, then 55h frame, then AAh frame
          if (st_ff.last_index == 4'h1 && st_ff.ul == U_LATCH &&
              st_ff.key == rsc_pkg::UNLOCK_KEY_A)
            nxt_st.ul = U_KEY_A;
          else if (st_ff.last_index == 4'h1 && st_ff.ul == U_KEY_A &&
                   st_ff.key == rsc_pkg::UNLOCK_KEY_B)
            nxt_st.ul = U_OPEN;
          else if (st_ff.last_index == 4'h0 && st_ff.latch)
            nxt_st.ul = U_LATCH; // Latch-set frame shares this opcode
          else
            nxt_st.ul = U_LOCKED;
        end
        K_ZERO, K_OTHER:
        begin
          // Two-byte zeroing command; second byte value ignored
          if (st_ff.kind == K_ZERO && st_ff.last_index == 4'h1 &&
              !ON_BATTERY)
            nxt_st.zero = 1'b1;
          nxt_st.ul = (st_ff.latch && st_ff.last_index == 4'h0 &&
                       st_ff.ul == U_LOCKED) ? U_LATCH : U_LOCKED;
        end
        default:
        begin
          nxt_st.ul = U_LOCKED;
        end
      endcase
      // A frame during a write cycle starts no NV, ID or status store; RTC writes, kicks and zeroing still act
    end
  end

  // State register with frozen state while enable is low
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_ff <= '0;
      st_ff.kind <= K_NONE;
      st_ff.ul <= U_LOCKED;
      st_ff.latch <= 1'b0;
      st_ff.prot <= rsc_pkg::PROT_RESET;
      st_ff.tx <= rsc_pkg::BYTE_RESET;
    end
    else if (CE)
      st_ff <= nxt_st;
  end

  // Outputs from registers; RD_ADDR also decodes the arriving address byte
  assign SO = link_so;
  // Address byte itself selects the first read byte as it arrives
  assign RD_ADDR = (new_byte && byte_s.index == 4'h1) ? byte_s.data :
                   (st_ff.kind == K_NONE) ? st_ff.ptr : wrap_inc(st_ff.ptr);
  assign RTC_WR = st_ff.wr_rtc;
  assign ID_WR = st_ff.wr_id;
  assign NV_WR = st_ff.wr_nv;
  assign PROT_NV_OUT = st_ff.prot;
  assign PROT_NV_STORE = st_ff.prot_store;
  assign WATCHDOG_KICK = st_ff.kick;
  assign SRAM_ZERO = st_ff.zero;
  assign STATUS_BUSY = st_ff.busy;
  assign STATUS_LATCH = st_ff.latch;
endmodule : rsc_cmd_core

// ---- tb/rsc_cmd_core_checker.sv ----
// Concurrent checks on the serial command block ports
`timescale 1ns/1ps
module rsc_cmd_core_checker #(
  parameter int NV_CYC = rsc_pkg::NV_WRITE_CYC
) (
  input logic MCLK,
  input logic RESETN,
  input logic ON_BATTERY,
  input rsc_pkg::rsc_wr_t RTC_WR,
  input rsc_pkg::rsc_wr_t ID_WR,
  input rsc_pkg::rsc_wr_t NV_WR,
  input logic [1:0] PROT_NV_OUT,
  input logic PROT_NV_STORE,
  input logic WATCHDOG_KICK,
  input logic SRAM_ZERO,
  input logic STATUS_BUSY,
  input logic STATUS_LATCH
);
  int busy_cnt; // Cycles spent in the current write cycle
  // Measure each nonvolatile write cycle
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      busy_cnt <= 0;
    else if (STATUS_BUSY)
      busy_cnt <= busy_cnt + 1;
    else
      busy_cnt <= 0;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // Latch drops within a few cycles of a commit
  sequence latch_gone_s;
    ##[0:4] !STATUS_LATCH;
  endsequence
  // Protected addresses never see a write
  chk_nv_protect: assert property (NV_WR.strobe |-> PROT_NV_OUT != 2'h3
    && !(PROT_NV_OUT == 2'h2 && NV_WR.addr >= rsc_pkg::PROT_HALF)
    && !(PROT_NV_OUT == 2'h1 && NV_WR.addr >= rsc_pkg::PROT_QUARTER))
    else $error("write into protected block");
  chk_latch_reset: assert property (disable iff (1'b0) !RESETN |->
    !STATUS_LATCH && !STATUS_BUSY) else $error("status set in reset");
  chk_nv_latch: assert property (NV_WR.strobe |-> STATUS_LATCH
    || $past(STATUS_LATCH) || $past(STATUS_LATCH, 2))
    else $error("nonvolatile write without latch");
  chk_latch_clear: assert property ((NV_WR.strobe || ID_WR.strobe
    || PROT_NV_STORE) |-> latch_gone_s) else $error("latch kept");
  chk_nv_gap: assert property (NV_WR.strobe |=> (!NV_WR.strobe)[*8])
    else $error("second write inside write cycle");
  chk_busy_len: assert property ($rose(STATUS_BUSY) |-> STATUS_BUSY[*8])
    else $error("write cycle too short");
  chk_busy_bound: assert property (busy_cnt <= NV_CYC + 8)
    else $error("write cycle too long");
  chk_battery_drop: assert property (ON_BATTERY && $past(ON_BATTERY, 4)
    |-> !RTC_WR.strobe) else $error("write on battery");
  chk_rtc_range: assert property (RTC_WR.strobe |->
    RTC_WR.addr <= rsc_pkg::SRAM_LAST) else $error("write past memory");
  chk_id_range: assert property (ID_WR.strobe |->
    ID_WR.addr <= rsc_pkg::ID_LAST) else $error("identity address out");
  chk_kick_pulse: assert property (WATCHDOG_KICK |=> !WATCHDOG_KICK)
    else $error("kick pulse too long");
  chk_zero_pulse: assert property (SRAM_ZERO |=> !SRAM_ZERO)
    else $error("zero pulse too long");
endmodule : rsc_cmd_core_checker

// ---- tb/rsc_host_model.sv ----
// Serial host that frames commands in link clock mode 0
`timescale 1ns/1ps
module rsc_host_model (
  output logic SCK,
  output logic CS_N,
  output logic SI,
  input logic SO
);
  localparam time HALF = 24; // Half of the 48 ns link period
  localparam time GAP = 500; // Pause the core needs between bytes
  // Link clock idles low, chip deselected
  initial
  begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end
  // One whole command; clock only runs inside the frame
  task automatic xfer(input int n, input logic [7:0] tx [16],
    output logic [7:0] rx [16]);
    CS_N = 1'b0;
    #(GAP);
    for (int i = 0; i < n; i++)
    begin
      for (int b = 7; b >= 0; b--)
      begin
        SI = tx[i][b];
        #(HALF);
        SCK = 1'b1;
        rx[i][b] = SO;
        #(HALF);
        SCK = 1'b0;
      end
      #(GAP);
    end
    CS_N = 1'b1;
    SI = ~SI;
    #(600);
  endtask : xfer
endmodule : rsc_host_model

// ---- tb/rsc_cmd_core_test.sv ----
// Self-checking bench for the serial command block
`timescale 1ns/1ps
module rsc_cmd_core_test;
  localparam int NV_CYC = 20; // Short write cycle for simulation
  localparam time DLY = 5; // Launch delay after the MCLK rise
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic CE = 1'b1;
  logic ON_BATTERY = 1'b0;
  logic SCK, CS_N, SI, SO, PROT_NV_STORE, WATCHDOG_KICK, SRAM_ZERO;
  logic STATUS_BUSY, STATUS_LATCH;
  logic [7:0] RD_ADDR, RD_DATA, ID_RD_DATA, NV_RD_DATA;
  logic [1:0] PROT_NV_OUT;
  rsc_pkg::rsc_wr_t RTC_WR, ID_WR, NV_WR, last_rtc, last_nv;
  logic [7:0] n_rtc = 8'h00, n_id = 8'h00, n_nv = 8'h00; // Commit counts
  logic [7:0] n_kick = 8'h00, n_zero = 8'h00; // Pulse counts
  logic [7:0] a, cnt, addr_tab [3];
  logic [7:0] tx [16];
  logic [7:0] rx [16];
  int n_fail = 0;
  int checked = 0;
  // Clock at 10 MHz
  always #50 MCLK = ~MCLK;
  // Fixed read pattern of the memories
  function automatic logic [7:0] pat(input logic [7:0] x);
    return x ^ 8'h5a;
  endfunction : pat
  assign RD_DATA = pat(RD_ADDR);
  assign ID_RD_DATA = ~RD_ADDR;
  assign NV_RD_DATA = ~RD_ADDR;
  rsc_cmd_core #(.NV_CYC(NV_CYC)) u_rsc_cmd_core (.MCLK(MCLK),
    .RESETN(RESETN), .CE(CE), .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
    .ON_BATTERY(ON_BATTERY), .PROT_NV_IN(rsc_pkg::PROT_RESET),
    .RD_DATA(RD_DATA), .ID_RD_DATA(ID_RD_DATA), .NV_RD_DATA(NV_RD_DATA),
    .RD_ADDR(RD_ADDR), .RTC_WR(RTC_WR), .ID_WR(ID_WR), .NV_WR(NV_WR),
    .PROT_NV_OUT(PROT_NV_OUT), .PROT_NV_STORE(PROT_NV_STORE),
    .WATCHDOG_KICK(WATCHDOG_KICK), .SRAM_ZERO(SRAM_ZERO),
    .STATUS_BUSY(STATUS_BUSY), .STATUS_LATCH(STATUS_LATCH));
  rsc_host_model u_rsc_host_model (.SCK(SCK), .CS_N(CS_N), .SI(SI),
    .SO(SO));
  // Count write commits, kicks and zero pulses; PROT_NV_STORE not counted
  always @(posedge MCLK)
  begin
    if (RTC_WR.strobe === 1'b1)
    begin
      n_rtc <= n_rtc + 8'h01;
      last_rtc <= RTC_WR;
    end
    if (NV_WR.strobe === 1'b1)
    begin
      n_nv <= n_nv + 8'h01;
      last_nv <= NV_WR;
    end
    if (ID_WR.strobe === 1'b1)
      n_id <= n_id + 8'h01;
    if (WATCHDOG_KICK === 1'b1)
      n_kick <= n_kick + 8'h01;
    if (SRAM_ZERO === 1'b1)
      n_zero <= n_zero + 8'h01;
  end
  // Compare a byte
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  // Compare a flag
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1
  // Send one frame, then wait for any write cycle to end
  task automatic cmd(input int n, input logic [7:0] b0,
    input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00,
    input logic [7:0] b3 = 8'h00);
    tx[0] = b0;
    tx[1] = b1;
    tx[2] = b2;
    tx[3] = b3;
    u_rsc_host_model.xfer(n, tx, rx);
    for (int i = 0; i < 200 && STATUS_BUSY !== 1'b0; i++)
      @(posedge MCLK);
    if (STATUS_BUSY !== 1'b0)
      n_fail++;
  endtask : cmd
  // Latch, first key, then the given second key
  task automatic unlock(input logic [7:0] key);
    cmd(1, rsc_pkg::OP_NV_LATCH_SET);
    cmd(2, rsc_pkg::OP_UNLOCK, rsc_pkg::UNLOCK_KEY_A);
    cmd(2, rsc_pkg::OP_UNLOCK, key);
  endtask : unlock
  // Print counts and verdict, then stop
  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  // Cut a hang short
  initial
  begin
    #(3000000);
    n_fail++;
    summarize();
  end
  // Main sequence
  initial
  begin
    addr_tab = '{8'h00, 8'h80, 8'hc0};
    repeat (20) @(posedge MCLK);
    #(DLY) RESETN = 1'b1;
    repeat (4) @(posedge MCLK);
    cmp1(STATUS_LATCH, 1'b0);
    cmp1(STATUS_BUSY, 1'b0);
    cmd(4, rsc_pkg::OP_WRITE, rsc_pkg::SRAM_LAST, 8'h11, 8'h22);
    cmp8(n_rtc, 8'h02);
    cmp8(last_rtc.addr, rsc_pkg::SRAM_FIRST);
    cmp8(last_rtc.data, 8'h22);
    cmd(4, rsc_pkg::OP_READ, rsc_pkg::CLK_REG_LAST);
    cmp8(rx[2], pat(rsc_pkg::CLK_REG_LAST));
    cmp8(rx[3], pat(rsc_pkg::CLK_REG_FIRST));
    @(posedge MCLK);
    #(DLY) ON_BATTERY = 1'b1;
    cmd(3, rsc_pkg::OP_WRITE, 8'h30, 8'h77);
    cmp8(n_rtc, 8'h02);
    cmd(3, rsc_pkg::OP_READ, 8'h30);
    cmp8(rx[2], 8'h00);
    @(posedge MCLK);
    #(DLY) ON_BATTERY = 1'b0;
    cmd(1, rsc_pkg::OP_WATCHDOG_KICK);
    cmp8(n_kick, 8'h01);
    cmd(2, rsc_pkg::OP_RAM_ZERO, 8'hff);
    cmp8(n_zero, 8'h01);
    cmd(3, rsc_pkg::OP_NV_WRITE, 8'h10, 8'haa);
    cmp8(n_nv, 8'h00);
    cmd(1, rsc_pkg::OP_LATCH_SET);
    cmd(2, rsc_pkg::OP_STATUS_READ);
    cmp8({6'h00, rx[1][1:0]}, 8'h02);
    cmd(3, rsc_pkg::OP_NV_WRITE, 8'h10, 8'haa);
    cmp8(n_nv, 8'h01);
    cmp8(last_nv.data, 8'haa);
    cmp1(STATUS_LATCH, 1'b0);
    // Every protect level against the bottom, half and quarter marks
    for (int lv = 0; lv < 4; lv++)
    begin
      cmd(1, rsc_pkg::OP_LATCH_SET);
      cmd(2, rsc_pkg::OP_STATUS_STORE, {4'h0, lv[1:0], 2'h0});
      cmp8({6'h00, PROT_NV_OUT}, {6'h00, lv[1:0]});
      for (int k = 0; k < 3; k++)
      begin
        a = addr_tab[k];
        cnt = n_nv;
        cmd(1, rsc_pkg::OP_LATCH_SET);
        cmd(3, rsc_pkg::OP_NV_WRITE, a, 8'h33);
        if (lv == 3 || (lv == 2 && a >= 8'h80) || (lv == 1 && a >= 8'hc0))
          cmp8(n_nv, cnt);
        else
          cmp8(n_nv, cnt + 8'h01);
      end
    end
    cmd(1, rsc_pkg::OP_LATCH_CLR);
    cmd(2, rsc_pkg::OP_STATUS_STORE, 8'h00);
    cmp8({6'h00, PROT_NV_OUT}, 8'h03);
    unlock(rsc_pkg::UNLOCK_KEY_B);
    cmd(3, rsc_pkg::OP_ID_STORE, 8'h00, 8'h01);
    cmp8(n_id, 8'h01);
    cmd(3, rsc_pkg::OP_ID_STORE, 8'h01, 8'h02);
    cmp8(n_id, 8'h01);
    unlock(rsc_pkg::UNLOCK_KEY_A);
    cmd(3, rsc_pkg::OP_ID_STORE, 8'h01, 8'h02);
    cmp8(n_id, 8'h01);
    unlock(rsc_pkg::UNLOCK_KEY_B);
    cmd(3, rsc_pkg::OP_WRITE, 8'h20, 8'h33);
    cmp1(STATUS_LATCH, 1'b0);
    cmd(3, rsc_pkg::OP_ID_STORE, 8'h01, 8'h02);
    cmp8(n_id, 8'h01);
    summarize();
  end
endmodule : rsc_cmd_core_test
bind rsc_cmd_core rsc_cmd_core_checker #(.NV_CYC(NV_CYC)) u_chk (.MCLK(MCLK),
  .RESETN(RESETN), .ON_BATTERY(ON_BATTERY), .RTC_WR(RTC_WR),
  .ID_WR(ID_WR), .NV_WR(NV_WR), .PROT_NV_OUT(PROT_NV_OUT),
  .PROT_NV_STORE(PROT_NV_STORE), .WATCHDOG_KICK(WATCHDOG_KICK),
  .SRAM_ZERO(SRAM_ZERO), .STATUS_BUSY(STATUS_BUSY),
  .STATUS_LATCH(STATUS_LATCH));
